// ==== src/cfg_link_if.sv ====
// Internal link between the register front end and its two helpers.
// Assumes all three share sys_clk; nothing here crosses a clock domain.
`timescale 1ns/1ps
interface cfg_link_if;
  logic [31:0] wdata;
  logic        stat_wr;
  logic        conf_wr;
  logic        vblank;
  logic [12:0] evt_raw;
  logic        underflow_evt;
  logic [31:0] stat_word;
  logic [12:0] evt_gated;
  logic        under_flag;
  logic [2:0]  fb_bpc;
  logic [5:0]  depth_word;
  logic [2:0]  out_bpc;
  logic        dither_on;
  logic        dither_st;

  modport top_side (output wdata, stat_wr, conf_wr, vblank, evt_raw, underflow_evt, fb_bpc,
                    input stat_word, evt_gated, under_flag, depth_word, out_bpc,
                    dither_on, dither_st);
  modport status_side (input wdata, stat_wr, evt_raw, underflow_evt,
                       output stat_word, evt_gated, under_flag);
  modport depth_side (input wdata, conf_wr, vblank, fb_bpc,
                      output depth_word, out_bpc, dither_on, dither_st);
endinterface : cfg_link_if

// ==== src/depth_dither_ctrl.sv ====
// Output colour depth and dithering control, double buffered on vblank.
// Assumes the frame buffer depth code arrives on sys_clk logic.
`timescale 1ns/1ps
module depth_dither_ctrl (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  // Link to the register front end
  cfg_link_if.depth_side       lnk
);
  logic [5:0] pend_r, pend_nxt, live_r;
  logic       dither_on_r, dither_st_r;
  wire        depth_differs = display_pipe_pkg::bpc_bits(live_r[5:3]) !=
                              display_pipe_pkg::bpc_bits(lnk.fb_bpc);

  assign pend_nxt = lnk.conf_wr ? lnk.wdata[display_pipe_pkg::CONF_DEPTH_LSB +: 6] : pend_r;

  // Pending value moves to live at vblank; a write in that cycle is taken
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pend_r      <= display_pipe_pkg::CONF_RESET[7:2];
      live_r      <= display_pipe_pkg::CONF_RESET[7:2];
      dither_on_r <= 1'b0;
      dither_st_r <= 1'b0;
    end
    else
    begin
      pend_r <= pend_nxt;
      if (lnk.vblank)
        live_r <= pend_nxt;
      dither_on_r <= live_r[2] & depth_differs;
      dither_st_r <= (live_r[1:0] == 2'h1);
    end
  end

  assign lnk.depth_word = pend_r;
  assign lnk.out_bpc    = live_r[5:3];
  assign lnk.dither_on  = dither_on_r;
  assign lnk.dither_st  = dither_st_r;
endmodule : depth_dither_ctrl

// ==== src/display_pipe_config_status.sv ====
// Configuration and status register bank for the second display pipe.
// Assumes register reads and writes and all pipe events come from logic
// on sys_clk, so no input needs a synchroniser.
//
// Behaviour
// - Bit 24 picks palette or interpolating gamma
// - Gamma mode reaches only the pipe gamma
// - Interlace field: immediate if off, else vblank
// - Interlace codes: progressive, embedded, shift, field0
// - Embedded panel code adjusts output timing
// - Bit 20: continuous refresh or on-demand updates
// - Bit 19 blanks planes from next vblank
// - Bits 7:5 colour depth, taken at vblank
// - Dither when output depth differs from buffer
// - Bit 4 dither enable, resets off
// - Bits 3:2 dither type, spatial by default
// - Three 17-bit gamma end points, reset 0x10000
// - Bit 31 underflow, sticky, write one clears
// - Bits 15,14 sprite flip done, write-one clear
// - Enables gate flips, vblank, frame start, hblank
// - Enables for perf counter, vsync, compare, refresh
// - Enables for odd and even field events
// - Enable for image brightness event
// - Vblank loads double buffers and sets status
`timescale 1ns/1ps
module display_pipe_config_status (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [19:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_rd_ack,
  // Pipe state and frame buffer format
  input  wire logic        pipe_active,
  input  wire logic [2:0]  fb_bpc_code,
  // Event pulses from the pipe
  input  wire logic        vblank_start,
  input  wire logic        frame_start,
  input  wire logic        hblank_start,
  input  wire logic        underflow_evt,
  input  wire logic        sprite4_flip_evt,
  input  wire logic        sprite3_flip_evt,
  input  wire logic        primary_flip_evt,
  input  wire logic        perf2_evt,
  input  wire logic        vsync_evt,
  input  wire logic        line_cmp_evt,
  input  wire logic        brightness_evt,
  input  wire logic        odd_field_evt,
  input  wire logic        even_field_evt,
  input  wire logic        self_refresh_evt,
  // Gamma controls
  output logic             gamma_ten_bit_mode,
  output logic      [16:0] gamma_max_red,
  output logic      [16:0] gamma_max_green,
  output logic      [16:0] gamma_max_blue,
  // Interlace controls
  output logic      [2:0]  interlace_mode,
  output logic             interlaced,
  output logic             embedded_panel_adjust,
  output logic             field0_only,
  // Refresh and plane controls
  output logic             self_refresh_on_demand,
  output logic             planes_forced_off,
  // Colour depth and dithering
  output logic      [2:0]  out_bpc_code,
  output logic             dither_active,
  output logic             dither_spatio_temporal,
  // Gated events and the ungated underflow flag toward first-level interrupt logic
  output logic      [12:0] first_level_events,
  output logic             underflow_seen
);

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  // Plain compares against full offsets; any other address is unmapped
  wire hit_conf = (reg_addr == display_pipe_pkg::OFS_PIPE_CONF);
  wire hit_red  = (reg_addr == display_pipe_pkg::OFS_GAMMA_RED);
  wire hit_grn  = (reg_addr == display_pipe_pkg::OFS_GAMMA_GRN);
  wire hit_blu  = (reg_addr == display_pipe_pkg::OFS_GAMMA_BLU);
  wire hit_stat = (reg_addr == display_pipe_pkg::OFS_EVT_STAT);

  wire conf_wr  = reg_wr & hit_conf;
  wire stat_wr  = reg_wr & hit_stat;
  wire [2:0] gamma_wr = {reg_wr & hit_blu, reg_wr & hit_grn, reg_wr & hit_red};

  // --------------------------------------------------------------------
  // Helper link
  // --------------------------------------------------------------------
  cfg_link_if lnk ();

  // Event vector in the order the status bank expects
  assign lnk.wdata         = reg_wdata;
  assign lnk.stat_wr       = stat_wr;
  assign lnk.conf_wr       = conf_wr;
  assign lnk.vblank        = vblank_start;
  assign lnk.underflow_evt = underflow_evt;
  assign lnk.fb_bpc        = fb_bpc_code;
  assign lnk.evt_raw       = {sprite4_flip_evt, sprite3_flip_evt, perf2_evt,
                              primary_flip_evt, vsync_evt, line_cmp_evt,
                              brightness_evt, odd_field_evt, even_field_evt,
                              self_refresh_evt, vblank_start, frame_start,
                              hblank_start};

  event_status_bank u_status (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .lnk     (lnk.status_side)
  );

  depth_dither_ctrl u_depth (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .lnk     (lnk.depth_side)
  );

  // --------------------------------------------------------------------
  // Pipe configuration, pending copies
  // --------------------------------------------------------------------
  logic       gamma_pend_r, sr_pend_r, off_pend_r, gamma_pend_nxt, sr_pend_nxt, off_pend_nxt;
  logic [2:0] ilace_pend_r, ilace_pend_nxt;

  // Software always reads back what it wrote, not the live copy
  assign gamma_pend_nxt = conf_wr ? reg_wdata[display_pipe_pkg::CONF_GAMMA_BIT] : gamma_pend_r;
  assign ilace_pend_nxt = conf_wr ? reg_wdata[display_pipe_pkg::CONF_ILACE_LSB +: 3]
                                  : ilace_pend_r;
  assign sr_pend_nxt    = conf_wr ? reg_wdata[display_pipe_pkg::CONF_SR_BIT] : sr_pend_r;
  assign off_pend_nxt   = conf_wr ? reg_wdata[display_pipe_pkg::CONF_OFF_BIT] : off_pend_r;

  // Pending registers
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gamma_pend_r <= display_pipe_pkg::CONF_RESET[24];
      ilace_pend_r <= display_pipe_pkg::CONF_RESET[23:21];
      sr_pend_r    <= display_pipe_pkg::CONF_RESET[20];
      off_pend_r   <= display_pipe_pkg::CONF_RESET[19];
    end
    else
    begin
      gamma_pend_r <= gamma_pend_nxt;
      ilace_pend_r <= ilace_pend_nxt;
      sr_pend_r    <= sr_pend_nxt;
      off_pend_r   <= off_pend_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Pipe configuration, live copies
  // --------------------------------------------------------------------
  logic       gamma_live_r, sr_live_r, off_live_r, interlaced_r, embedded_r, field0_r;
  logic [2:0] ilace_live_r, ilace_live_nxt;

  // Interlace skips the double buffer while the pipe is off, since no
  // vblank would ever arrive to load it
  wire ilace_now = conf_wr & ~pipe_active;
  assign ilace_live_nxt = (ilace_now | vblank_start) ? ilace_pend_nxt
                                                     : ilace_live_r;

  // Live registers follow pending ones at vblank start
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gamma_live_r <= display_pipe_pkg::CONF_RESET[24];
      sr_live_r    <= display_pipe_pkg::CONF_RESET[20];
      off_live_r   <= display_pipe_pkg::CONF_RESET[19];
    end
    else if (vblank_start)
    begin
      gamma_live_r <= gamma_pend_nxt;
      sr_live_r    <= sr_pend_nxt;
      off_live_r   <= off_pend_nxt;
    end
  end

  // Interlace code and its decoded flags share one edge
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ilace_live_r <= display_pipe_pkg::CONF_RESET[23:21];
      interlaced_r <= 1'b0;
      embedded_r   <= 1'b0;
      field0_r     <= 1'b0;
    end
    else
    begin
      ilace_live_r <= ilace_live_nxt;
      interlaced_r <= ilace_live_nxt[2];
      embedded_r   <= (ilace_live_nxt == display_pipe_pkg::ILACE_EMBEDDED);
      field0_r     <= (ilace_live_nxt == display_pipe_pkg::ILACE_FIELD0);
    end
  end

  // --------------------------------------------------------------------
  // Gamma end points
  // --------------------------------------------------------------------
  // No clamp at 1024.0: software owns the range, hardware stores all bits
  logic [16:0] gamma_max_r [3];

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_gamma
      always_ff @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
          gamma_max_r[g] <= display_pipe_pkg::GAMMA_RESET;
        else if (gamma_wr[g])
          gamma_max_r[g] <= reg_wdata[16:0];
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Readback
  // --------------------------------------------------------------------
  wire [31:0] conf_word = {1'b0, pipe_active, 5'h00, gamma_pend_r, ilace_pend_r,
                           sr_pend_r, off_pend_r, 11'h000, lnk.depth_word, 2'h0};
  wire [31:0] rd_data_nxt =
    hit_conf ? conf_word :
    hit_red  ? {15'h0000, gamma_max_r[0]} :
    hit_grn  ? {15'h0000, gamma_max_r[1]} :
    hit_blu  ? {15'h0000, gamma_max_r[2]} :
    hit_stat ? lnk.stat_word :
               32'h0000_0000;

  // Read data is held until the next read; unmapped reads return zero
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata  <= 32'h0000_0000;
      reg_rd_ack <= 1'b0;
    end
    else
    begin
      reg_rd_ack <= reg_rd;
      if (reg_rd)
        reg_rdata <= rd_data_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Gamma mode drives only the pipe corrector; overlay and sprite
  // correctors take no input from this block
  assign gamma_ten_bit_mode     = gamma_live_r;
  assign gamma_max_red          = gamma_max_r[0];
  assign gamma_max_green        = gamma_max_r[1];
  assign gamma_max_blue         = gamma_max_r[2];
  assign interlace_mode         = ilace_live_r;
  assign interlaced             = interlaced_r;
  assign embedded_panel_adjust  = embedded_r;
  assign field0_only            = field0_r;
  assign self_refresh_on_demand = sr_live_r;
  assign planes_forced_off      = off_live_r;
  assign out_bpc_code           = lnk.out_bpc;
  assign dither_active          = lnk.dither_on;
  assign dither_spatio_temporal = lnk.dither_st;
  assign first_level_events     = lnk.evt_gated;
  assign underflow_seen         = lnk.under_flag;

endmodule : display_pipe_config_status

// ==== src/display_pipe_pkg.sv ====
// Constants for the second display pipe configuration and status registers.
// Assumes a single register port on sys_clk and 32-bit register words.
package display_pipe_pkg;

  // --------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------
  localparam logic [19:0] OFS_PIPE_CONF  = 20'h7_1008;
  localparam logic [19:0] OFS_GAMMA_RED  = 20'h7_1010;
  localparam logic [19:0] OFS_GAMMA_GRN  = 20'h7_1014;
  localparam logic [19:0] OFS_GAMMA_BLU  = 20'h7_1018;
  localparam logic [19:0] OFS_EVT_STAT   = 20'h7_1024;

  // --------------------------------------------------------------------
  // Field positions and reset values
  // --------------------------------------------------------------------
  localparam int CONF_STATE_BIT  = 30;
  localparam int CONF_GAMMA_BIT  = 24;
  localparam int CONF_ILACE_LSB  = 21;
  localparam int CONF_SR_BIT     = 20;
  localparam int CONF_OFF_BIT    = 19;
  localparam int CONF_DEPTH_LSB  = 2;
  localparam int STAT_UNDER_BIT  = 31;
  localparam int NUM_EVT         = 13;
  // Event order: sprite4 flip, sprite3 flip, perf2, primary flip, vsync,
  // line compare, brightness, odd field, even field, self refresh,
  // vblank start, frame start, hblank
  localparam int EVT_STAT_POS [NUM_EVT] = '{15, 14, 11, 10, 9, 8, 7, 5, 4, 3, 2, 1, 0};
  localparam int EVT_EN_POS   [NUM_EVT] = '{30, 22, 27, 26, 25, 24, 23, 21, 20, 19, 18, 17, 16};
  localparam logic [31:0] CONF_RESET  = 32'h0000_0000;
  localparam logic [31:0] STAT_RESET  = 32'h0000_0000;
  localparam logic [16:0] GAMMA_RESET = 17'h1_0000;

  // --------------------------------------------------------------------
  // Encodings
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    BPC_8  = 3'h0,
    BPC_10 = 3'h1,
    BPC_6  = 3'h2
  } bpc_code_type;

  typedef enum logic [2:0] {
    ILACE_EMBEDDED  = 3'h4,
    ILACE_VS_SHIFT  = 3'h5,
    ILACE_SYNC_FLD  = 3'h6,
    ILACE_FIELD0    = 3'h7
  } ilace_code_type;

  // Bits per colour for a depth code, zero for reserved codes
  function automatic logic [3:0] bpc_bits(input logic [2:0] code);
    case (code)
      BPC_8:   bpc_bits = 4'h8;
      BPC_10:  bpc_bits = 4'hA;
      BPC_6:   bpc_bits = 4'h6;
      default: bpc_bits = 4'h0;
    endcase
  endfunction : bpc_bits

endpackage : display_pipe_pkg

// ==== src/event_status_bank.sv ====
// Sticky event status bits with their enables, gated toward interrupt logic.
// Assumes event inputs are one-cycle pulses on sys_clk.
`timescale 1ns/1ps
module event_status_bank (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  // Link to the register front end
  cfg_link_if.status_side      lnk
);
  logic [12:0] stat_r, stat_nxt, en_r, en_nxt, gated_r;
  logic        under_r, under_nxt;

  // Set wins over a clear in the same cycle so no event is lost
  genvar i;
  generate
    for (i = 0; i < display_pipe_pkg::NUM_EVT; i++)
    begin : g_evt
      // Table entry 0 is the top event, so vector bit i uses the mirrored entry
      localparam int SP = display_pipe_pkg::EVT_STAT_POS[display_pipe_pkg::NUM_EVT - 1 - i];
      localparam int EP = display_pipe_pkg::EVT_EN_POS[display_pipe_pkg::NUM_EVT - 1 - i];
      assign stat_nxt[i] = lnk.evt_raw[i] |
                           (stat_r[i] & ~(lnk.stat_wr & lnk.wdata[SP]));
      assign en_nxt[i]   = lnk.stat_wr ? lnk.wdata[EP] : en_r[i];
    end
  endgenerate
  assign under_nxt = lnk.underflow_evt |
                     (under_r & ~(lnk.stat_wr & lnk.wdata[display_pipe_pkg::STAT_UNDER_BIT]));

  // Status, enables and the gated view all move on the same edge
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stat_r  <= display_pipe_pkg::STAT_RESET[12:0];
      en_r    <= display_pipe_pkg::STAT_RESET[12:0];
      under_r <= 1'b0;
      gated_r <= 13'h0000;
    end
    else
    begin
      stat_r  <= stat_nxt;
      en_r    <= en_nxt;
      under_r <= under_nxt;
      gated_r <= stat_nxt & en_nxt;
    end
  end

  // Readback word; reserved bits read zero
  always_comb
  begin
    lnk.stat_word = 32'h0000_0000;
    for (int k = 0; k < display_pipe_pkg::NUM_EVT; k++)
    begin
      lnk.stat_word[display_pipe_pkg::EVT_STAT_POS[k]] = stat_r[display_pipe_pkg::NUM_EVT-1-k];
      lnk.stat_word[display_pipe_pkg::EVT_EN_POS[k]]   = en_r[display_pipe_pkg::NUM_EVT-1-k];
    end
    lnk.stat_word[display_pipe_pkg::STAT_UNDER_BIT] = under_r;
  end
  assign lnk.evt_gated  = gated_r;
  assign lnk.under_flag = under_r;
endmodule : event_status_bank

// ==== testbench/display_pipe_config_status_asserts.sv ====
// Port-level checker for the pipe configuration and status register bank.
// Assumes one clock domain, sys_clk, with rst_b as its asynchronous reset.
`timescale 1ns/1ps
module display_pipe_config_status_asserts (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // Register port and pipe inputs
  input wire logic [19:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_rd_ack,
  input wire logic        pipe_active,
  input wire logic        vblank_start,
  input wire logic        underflow_evt,
  // Observed controls
  input wire logic [16:0] gamma_max_red,
  input wire logic        gamma_ten_bit_mode,
  input wire logic [2:0]  interlace_mode,
  input wire logic        interlaced,
  input wire logic        embedded_panel_adjust,
  input wire logic        field0_only,
  input wire logic        self_refresh_on_demand,
  input wire logic        planes_forced_off,
  input wire logic [2:0]  out_bpc_code,
  input wire logic        underflow_seen
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Request shapes
  // ----------------------------------------------------------------
  sequence s_conf_wr_idle;
    reg_wr && reg_addr == display_pipe_pkg::OFS_PIPE_CONF && !pipe_active;
  endsequence
  // Event in the same cycle wins, so only a clean clear is expected
  sequence s_under_clr;
    reg_wr && reg_addr == display_pipe_pkg::OFS_EVT_STAT && reg_wdata[31] && !underflow_evt;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_rd_ack;
    reg_rd |=> reg_rd_ack;
  endproperty
  property p_no_ack;
    !reg_rd |=> !reg_rd_ack;
  endproperty
  property p_gamma_wr;
    reg_wr && reg_addr == display_pipe_pkg::OFS_GAMMA_RED |=> gamma_max_red == $past(reg_wdata[16:0]);
  endproperty
  property p_ilace_now;
    s_conf_wr_idle |=> interlace_mode == $past(reg_wdata[23:21]);
  endproperty
  property p_ilace_hold;
    !vblank_start && !(reg_wr && !pipe_active) |=> $stable(interlace_mode);
  endproperty
  property p_live_hold;
    !vblank_start |=> $stable({gamma_ten_bit_mode, self_refresh_on_demand, planes_forced_off,
      out_bpc_code});
  endproperty
  property p_flags;
    interlaced == interlace_mode[2] && field0_only == (interlace_mode == 3'h7)
      && embedded_panel_adjust == (interlace_mode == 3'h4);
  endproperty
  property p_under_set;
    underflow_evt |=> underflow_seen;
  endproperty
  property p_under_clr;
    s_under_clr |=> !underflow_seen;
  endproperty

  a_rd_ack: assert property (p_rd_ack) else $error("read not acknowledged");
  a_no_ack: assert property (p_no_ack) else $error("stray read acknowledge");
  a_gamma_wr: assert property (p_gamma_wr) else $error("red end point not stored");
  a_ilace_now: assert property (p_ilace_now) else $error("interlace not immediate");
  a_ilace_hold: assert property (p_ilace_hold) else $error("interlace moved early");
  a_live_hold: assert property (p_live_hold) else $error("live field moved early");
  a_flags: assert property (p_flags) else $error("interlace decode wrong");
  a_under_set: assert property (p_under_set) else $error("underflow not seen");
  a_under_clr: assert property (p_under_clr) else $error("underflow not cleared");
endmodule : display_pipe_config_status_asserts

bind display_pipe_config_status display_pipe_config_status_asserts i_asserts (.*);

// ==== testbench/display_pipe_config_status_test.sv ====
// Self-checking bench for the pipe configuration and status register bank.
// Assumes the strobe register port of the design and one-cycle event pulses.
`timescale 1ns/1ps
module display_pipe_config_status_test;
  localparam logic [31:0] CONF_MASK = 32'h01f8_00fc;
  localparam logic [19:0] UNMAPPED  = 20'h7_100c;
  // Stimulus
  logic        sys_clk, rst_b, reg_wr, reg_rd, pipe_active, under_in;
  logic [19:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [2:0]  fb_bpc_code;
  logic [12:0] ev;
  // Observed
  logic [31:0] reg_rdata;
  logic        reg_rd_ack, gamma_ten_bit_mode, interlaced, embedded_panel_adjust, field0_only;
  logic        self_refresh_on_demand, planes_forced_off, dither_active, dither_spatio_temporal;
  logic        underflow_seen;
  logic [16:0] gam_r, gam_g, gam_b;
  logic [2:0]  interlace_mode, out_bpc_code;
  logic [12:0] first_level_events;
  // Model state
  logic [31:0] conf_m, live_m, stat_m, d, r;
  logic [16:0] gam_m [3];
  int          seed = 32'ha14f;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;

  display_pipe_config_status i_display_pipe_config_status (
    .*, .vblank_start(ev[2]), .frame_start(ev[1]), .hblank_start(ev[0]),
    .underflow_evt(under_in), .sprite4_flip_evt(ev[12]), .sprite3_flip_evt(ev[11]),
    .primary_flip_evt(ev[9]), .perf2_evt(ev[10]), .vsync_evt(ev[8]), .line_cmp_evt(ev[7]),
    .brightness_evt(ev[6]), .odd_field_evt(ev[5]), .even_field_evt(ev[4]),
    .self_refresh_evt(ev[3]), .gamma_max_red(gam_r), .gamma_max_green(gam_g),
    .gamma_max_blue(gam_b));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Whole run needs about 370 cycles; the ceiling leaves wide margin
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Model helpers and checks
  // ----------------------------------------------------------------
  function automatic int depth(input logic [2:0] c);
    depth = (c == 3'h0) ? 8 : (c == 3'h1) ? 10 : (c == 3'h2) ? 6 : 0;
  endfunction : depth
  function automatic logic [12:0] fle_exp();
    for (int i = 0; i < 13; i++)
      fle_exp[12-i] = stat_m[display_pipe_pkg::EVT_STAT_POS[i]]
        & stat_m[display_pipe_pkg::EVT_EN_POS[i]];
  endfunction : fle_exp
  task automatic chk_out(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_out
  task automatic wr(input logic [19:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    #1 {reg_addr, reg_wdata, reg_wr} = {a, v, 1'b1};
    @(posedge sys_clk);
    #1 reg_wr = 1'b0;
    if (a == display_pipe_pkg::OFS_PIPE_CONF)
    begin
      conf_m = v & CONF_MASK;
      if (!pipe_active)
        live_m[23:21] = v[23:21];
    end
    if (a == display_pipe_pkg::OFS_EVT_STAT)
      stat_m = (stat_m & ~v & 32'h8000_cfbf) | (v & 32'h4fff_0000);
    for (int k = 0; k < 3; k++)
      if (a == display_pipe_pkg::OFS_GAMMA_RED + 20'(4 * k))
        gam_m[k] = v[16:0];
  endtask : wr
  // Read and compare; a missing acknowledge shows as a mismatch
  task automatic chk_rd(input logic [19:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    #1 {reg_addr, reg_rd} = {a, 1'b1};
    @(posedge sys_clk);
    #1 reg_rd = 1'b0;
    chk_out((reg_rd_ack === 1'b1) ? reg_rdata : ~exp, exp);
  endtask : chk_rd
  task automatic pulse(input logic [12:0] v, input logic u);
    @(posedge sys_clk);
    #1 {ev, under_in} = {v, u};
    @(posedge sys_clk);
    #1 {ev, under_in} = 14'h0;
    if (v[2])
      live_m = conf_m;
    for (int i = 0; i < 13; i++)
      if (v[12-i])
        stat_m[display_pipe_pkg::EVT_STAT_POS[i]] = 1'b1;
    if (u)
      stat_m[31] = 1'b1;
  endtask : pulse
  // One extra edge lets the dither decision settle after a live change
  task automatic chk_live();
    @(posedge sys_clk);
    #1;
    chk_out(gamma_ten_bit_mode, live_m[24]);
    chk_out(interlace_mode, live_m[23:21]);
    chk_out({interlaced, embedded_panel_adjust, field0_only}, {live_m[23],
      live_m[23:21] == 3'h4, live_m[23:21] == 3'h7});
    chk_out({self_refresh_on_demand, planes_forced_off}, live_m[20:19]);
    chk_out(out_bpc_code, live_m[7:5]);
    chk_out({dither_active, dither_spatio_temporal}, {live_m[4] && depth(live_m[7:5])
      != depth(fb_bpc_code), live_m[3:2] == 2'h1});
    chk_out(first_level_events, fle_exp());
    chk_out(underflow_seen, stat_m[31]);
    chk_out({gam_r, gam_g, gam_b}, {gam_m[0], gam_m[1], gam_m[2]});
  endtask : chk_live
  task automatic do_reset();
    #1 rst_b = 1'b0;
    {conf_m, live_m, stat_m} = 96'h0;
    gam_m = '{3{display_pipe_pkg::GAMMA_RESET}};
    repeat (10) @(posedge sys_clk);
    #1 rst_b = 1'b1;
  endtask : do_reset
  task complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {reg_addr, reg_wr, reg_rd, reg_wdata, pipe_active, fb_bpc_code, ev, under_in} = 0;
    do_reset();
    chk_live();
    chk_rd(display_pipe_pkg::OFS_EVT_STAT, 32'h0);
    chk_rd(UNMAPPED, 32'h0);
    // Gamma end points, reserved upper bits dropped
    for (int k = 0; k < 3; k++)
    begin
      chk_rd(display_pipe_pkg::OFS_GAMMA_RED + 20'(4 * k), 32'h0001_0000);
      d = $random(seed);
      wr(display_pipe_pkg::OFS_GAMMA_RED + 20'(4 * k), d);
      chk_rd(display_pipe_pkg::OFS_GAMMA_RED + 20'(4 * k), d & 32'h0001_ffff);
    end
    wr(UNMAPPED, $random(seed));
    chk_rd(UNMAPPED, 32'h0);
    // Every interlace and depth code, pipe idle and running in turn
    for (int k = 0; k < 16; k++)
    begin
      pipe_active = k[0];
      fb_bpc_code = 3'(k / 3);
      d = $random(seed);
      d[23:21] = k[3:1];
      d[7:5] = ~k[3:1];
      wr(display_pipe_pkg::OFS_PIPE_CONF, d);
      chk_rd(display_pipe_pkg::OFS_PIPE_CONF, conf_m | {1'b0, k[0], 30'h0});
      chk_live();
      pulse(13'h0004, 1'b0);
      chk_live();
    end
    // Random enables, clears and events; status starts with vblank set from above
    for (int k = 0; k < 24; k++)
    begin
      wr(display_pipe_pkg::OFS_EVT_STAT, $random(seed));
      chk_live();
      r = $random(seed);
      pulse(r[12:0], r[13]);
      chk_live();
      chk_rd(display_pipe_pkg::OFS_EVT_STAT, stat_m);
    end
    // Second reset in mid-run restores every default
    do_reset();
    chk_live();
    chk_rd(display_pipe_pkg::OFS_EVT_STAT, 32'h0);
    complete_run();
  end
endmodule : display_pipe_config_status_test
